// ---- pkg/bias_cmp_pkg.sv ----
/*
  Shared constants for the bias regulator and comparator control block:
  register map, field positions, reset values and deglitch timing.
  Assumes a single 40 MHz core clock and word-aligned register offsets.
*/
package bias_cmp_pkg;

  // Core clock rate
  localparam int SYS_CLK_MHZ = 40;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_BIAS_CTRL = 8'h00;  // Bias regulator control
  localparam logic [7:0] ADDR_CMP_CTRL  = 8'h04;  // Comparator control
  localparam logic [7:0] ADDR_STATUS    = 8'h08;  // Live status, read only
  localparam logic [7:0] ADDR_INT_STAT  = 8'h0c;  // Sticky events, write one to clear
  localparam logic [7:0] ADDR_INT_MASK  = 8'h10;  // Interrupt enables

  ////////////////////////////////////////////////////////////////////////////
  // Bias control fields
  localparam int B_EXT_SEL  = 0;  // external_bias_select
  localparam int B_LP_MODE  = 1;  // low_power_mode_bit
  localparam int B_LPB_EN   = 2;  // low_power_bias_enable
  localparam int B_OTG_EN   = 3;  // Converter start request, OTG
  localparam int B_VAP_EN   = 4;  // Converter start request, VAP
  localparam logic [4:0] BIAS_CTRL_RST = 5'h02;  // Low-power mode out of reset

  // Comparator control fields
  localparam int C_IN_SEL   = 0;  // comparator_input_select
  localparam int C_LATCH_EN = 1;  // comparator_latch_enable
  localparam int C_POL      = 2;  // comparator_polarity
  localparam int C_DEG_LO   = 3;  // comparator_deglitch_select, two bits
  localparam int C_FRC_EN   = 5;  // forced_converter_off_enable
  localparam int C_ADC_EN   = 6;  // comparator_adc_channel_enable
  localparam int C_LPCMP_EN = 7;  // low_power_comparator_enable
  localparam logic [7:0] CMP_CTRL_RST = 8'h00;

  // Event bits, shared by status, sticky and mask registers
  localparam int E_BIAS_OV  = 0;
  localparam int E_FRC_OFF  = 1;
  localparam int E_AC_GONE  = 2;
  localparam int NUM_EVENTS = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Deglitch durations in ns, minimum times so cycle counts round up
  localparam int DEG0_NS = 1000;
  localparam int DEG1_NS = 2000;
  localparam int DEG2_NS = 5000;
  localparam int DEG3_NS = 10000;
  localparam int DEG0_CYC = (DEG0_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DEG1_CYC = (DEG1_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DEG2_CYC = (DEG2_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DEG3_CYC = (DEG3_NS * SYS_CLK_MHZ + 999) / 1000;

endpackage

// ---- pkg/deglitch_if.sv ----
/*
  Carrier between the control core and its comparator deglitch filter.
  Assumes both ends run on the same core clock.
*/
interface deglitch_if;
  logic       raw;     // Unfiltered comparator level
  logic [1:0] sel;     // Duration select
  logic       filt;    // Filtered level

  // Control core side
  modport ctrl (output raw, output sel, input filt);
  // Filter side
  modport filter (input raw, input sel, output filt);
endinterface

// ---- core/pin_sync.sv ----
/*
  Three-stage synchroniser for asynchronous levels.
  Assumes slow levels; stages two and three must agree.
*/
module pin_sync
  import bias_cmp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output wire logic [WIDTH-1:0] sync_out
);

  // All stages in one record
  typedef struct packed {
    logic [WIDTH-1:0] s1;   // Metastable stage, feeds s2 only
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;  // Accepted level
  } sync_type;

  sync_type r_q;
  sync_type r_d;

  // Next state
  always_comb
  begin
    r_d    = r_q;
    r_d.s1 = async_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      // Agreement of stages two and three qualifies a change
      if (r_q.s2[i] == r_q.s3[i])
        r_d.out[i] = r_q.s3[i];
    end
  end

  // Register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      r_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, out: RST_VAL};
    else
      r_q <= r_d;
  end

  assign sync_out = r_q.out;

endmodule

// ---- core/cmp_deglitch.sv ----
/*
  Comparator deglitch filter: a new level passes only after the raw
  level has held for the whole selected duration.
  Assumes a synchronised raw level; idles high like the comparator.
*/
module cmp_deglitch
  import bias_cmp_pkg::*;
#(
  parameter int CNT_W = 16
)(
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   srst,
  // Filter path
  deglitch_if.filter  dg
);

  // Filter state
  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // Cycles the raw level has differed
    logic             filt;  // Output level
  } dg_type;

  dg_type           r_q;
  dg_type           r_d;
  logic [CNT_W-1:0] limit;   // Cycles required for the selection

  // Duration lookup
  always_comb
  begin
    case (dg.sel)
      2'h0:    limit = CNT_W'(DEG0_CYC);
      2'h1:    limit = CNT_W'(DEG1_CYC);
      2'h2:    limit = CNT_W'(DEG2_CYC);
      default: limit = CNT_W'(DEG3_CYC);
    endcase
  end

  // Any bounce restarts the count, so glitches never leak through
  always_comb
  begin
    r_d = r_q;
    if (dg.raw == r_q.filt)
      r_d.cnt = '0;
    else if (r_q.cnt + CNT_W'(1) >= limit)
    begin
      r_d.filt = dg.raw;
      r_d.cnt  = '0;
    end
    else
      r_d.cnt = r_q.cnt + CNT_W'(1);
  end

  // Register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      r_q <= '{cnt: '0, filt: 1'b1};
    else
      r_q <= r_d;
  end

  assign dg.filt = r_q.filt;

endmodule

// ---- core/bias_cmp_ctrl.sv ----
/*
  Control core for the bias regulator and the independent comparator:
  bias source choice, bias target and capability, external bias
  overvoltage response, comparator muxing, latch, deglitch and the
  forced converter-off protection, plus a small register file.
  Assumes analog comparisons arrive as asynchronous levels and that
  software uses a simple strobe bus with read data one cycle later.
*/
// Local design decisions: the address map and the strobed register port.
module bias_cmp_ctrl
  import bias_cmp_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output wire logic [31:0] reg_rdata,
  // Analog comparison levels, asynchronous
  input  wire logic       input_rail_above_6v,
  input  wire logic       system_rail_above_6v,
  input  wire logic       input_rail_above_system,
  input  wire logic       ext_bias_overvoltage,
  input  wire logic       comparator_input_pin,
  input  wire logic       adapter_present,
  // Bias regulator controls
  output wire logic       bias_from_system_rail,
  output wire logic       bias_target_low,
  output wire logic       bias_limit_one,
  output wire logic       bias_regulator_on,
  output wire logic       bias_full_scale,
  // Comparator controls
  output wire logic       comparator_on,
  output wire logic       comparator_hyst_on,
  output wire logic       comparator_adc_channel_enable,
  // Converter and host signalling
  output wire logic       converter_switch_en,
  output wire logic       charge_ok_status_out,
  output wire logic       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    logic [4:0]            bias_ctrl;    // Bias control register
    logic [7:0]            cmp_ctrl;     // Comparator control register
    logic [NUM_EVENTS-1:0] int_stat;     // Sticky events
    logic [NUM_EVENTS-1:0] int_mask;     // Event enables
    logic [31:0]           rdata;        // Read data, one cycle only
    logic                  held_low;     // Latched comparator trigger
    logic                  fault;        // forced_off_fault_bit
    logic                  ov_fault;     // bias_overvoltage_fault
    logic                  ac_prev;      // Adapter level, last cycle
    logic                  out_bits;     // Registered comparator output
    logic                  bias_sys;     // Selected rail
    logic                  bias_on;      // Regulator enable
    logic                  bias_full;    // Full capability
    logic                  conv_en;      // Converter switching enable
    logic                  chg_ok;       // charge_ok_status_out
  } ctrl_type;

  ctrl_type   r_q;        // Registered state
  ctrl_type   r_d;        // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs

  logic [5:0] lvl;        // Qualified pin levels
  logic       in6;        // Input rail above six volts
  logic       sys6;       // System rail above six volts
  logic       in_gt_sys;  // Input rail higher than system rail
  logic       ext_ov;     // External bias over threshold
  logic       cmp_pin;    // Raw comparator decision
  logic       ac_ok;      // Adapter attached

  // Comparator idles high, so its stages reset high
  pin_sync #(
    .WIDTH   (6),
    .RST_VAL (6'h10)
  ) u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in ({adapter_present, comparator_input_pin, ext_bias_overvoltage,
                input_rail_above_system, system_rail_above_6v,
                input_rail_above_6v}),
    .sync_out (lvl)
  );

  assign in6       = lvl[0];
  assign sys6      = lvl[1];
  assign in_gt_sys = lvl[2];
  assign ext_ov    = lvl[3];
  assign cmp_pin   = lvl[4];
  assign ac_ok     = lvl[5];

  ////////////////////////////////////////////////////////////////////////////
  // Field views

  logic       ext_sel;    // external_bias_select
  logic       lp_mode;    // low_power_mode_bit
  logic       lpb_en;     // low_power_bias_enable
  logic       conv_req;   // OTG or VAP asked for the converter
  logic       pin_to_cmp; // Pin routed to the comparator
  logic       latch_en;   // comparator_latch_enable
  logic       pol_high;   // comparator_polarity
  logic       frc_en;     // forced_converter_off_enable
  logic       cmp_act;    // Comparator powered and routed

  assign ext_sel    = r_q.bias_ctrl[B_EXT_SEL];
  assign lp_mode    = r_q.bias_ctrl[B_LP_MODE];
  assign lpb_en     = r_q.bias_ctrl[B_LPB_EN];
  assign conv_req   = r_q.bias_ctrl[B_OTG_EN] | r_q.bias_ctrl[B_VAP_EN];
  assign pin_to_cmp = ~r_q.cmp_ctrl[C_IN_SEL];
  assign latch_en   = r_q.cmp_ctrl[C_LATCH_EN];
  assign pol_high   = r_q.cmp_ctrl[C_POL];
  assign frc_en     = r_q.cmp_ctrl[C_FRC_EN];

  // Battery-only low power keeps the comparator dark unless enabled
  assign cmp_act = pin_to_cmp
                 & ~(lp_mode & ~ac_ok & ~r_q.cmp_ctrl[C_LPCMP_EN]);

  ////////////////////////////////////////////////////////////////////////////
  // Deglitch filter

  deglitch_if dg ();

  // Idle comparator reads as untriggered, i.e. high
  assign dg.raw = cmp_act ? cmp_pin : 1'b1;
  assign dg.sel = r_q.cmp_ctrl[C_DEG_LO +: 2];

  cmp_deglitch #(
    .CNT_W (16)
  ) u_deglitch (
    .sys_clk (sys_clk),
    .srst    (srst),
    .dg      (dg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic                  wr_bias;   // Write to bias control
  logic                  wr_cmp;    // Write to comparator control
  logic                  wr_clr;    // Write to sticky events
  logic                  wr_mask;   // Write to mask
  logic                  cmp_out;   // Comparator output after latch
  logic                  ac_gone;   // Adapter removal edge
  logic [NUM_EVENTS-1:0] events;    // Event pulses
  logic [NUM_EVENTS-1:0] live;      // Live status bits

  always_comb
  begin
    r_d     = r_q;
    wr_bias = reg_wr & (reg_addr == ADDR_BIAS_CTRL);
    wr_cmp  = reg_wr & (reg_addr == ADDR_CMP_CTRL);
    wr_clr  = reg_wr & (reg_addr == ADDR_INT_STAT);
    wr_mask = reg_wr & (reg_addr == ADDR_INT_MASK);

    // Register writes
    if (wr_bias)
      r_d.bias_ctrl = reg_wdata[4:0];
    if (wr_cmp)
      r_d.cmp_ctrl = reg_wdata[7:0];
    if (wr_mask)
      r_d.int_mask = reg_wdata[NUM_EVENTS-1:0];

    // Latch: a trigger is held while enabled; dropping the enable clears it
    if (~latch_en)
      r_d.held_low = 1'b0;
    else if (~dg.filt)
      r_d.held_low = 1'b1;
    cmp_out    = dg.filt & ~r_q.held_low;
    r_d.out_bits = cmp_out;

    // Forced converter off; removal of the adapter clears it for one cycle
    ac_gone   = r_q.ac_prev & ~ac_ok;
    r_d.ac_prev = ac_ok;
    if (ac_gone)
      r_d.fault = 1'b0;
    else
      r_d.fault = frc_en & ~cmp_out;

    // External bias overvoltage follows the qualified level
    r_d.ov_fault = ext_ov;

    // Bias rail choice against the six-volt thresholds
    if (in6 & sys6)
      r_d.bias_sys = in_gt_sys;
    else if (~in6 & ~sys6)
      r_d.bias_sys = ~in_gt_sys;
    else
      r_d.bias_sys = sys6;

    // Performance mode always full; low power only on demand
    if (~lp_mode)
    begin
      r_d.bias_on   = 1'b1;
      r_d.bias_full = 1'b1;
    end
    else
    begin
      r_d.bias_on   = lpb_en | conv_req | ac_ok;
      r_d.bias_full = conv_req | ac_ok;
    end

    // Either fault stops switching and pulls status low
    r_d.conv_en = (ac_ok | conv_req) & ~r_q.fault & ~r_q.ov_fault;
    r_d.chg_ok  = ac_ok & ~r_q.fault & ~r_q.ov_fault;

    // Sticky events; a new event beats a simultaneous clear
    events = '0;
    events[E_BIAS_OV] = ext_ov & ~r_q.ov_fault;
    events[E_FRC_OFF] = r_d.fault & ~r_q.fault;
    events[E_AC_GONE] = ac_gone;
    if (wr_clr)
      r_d.int_stat = r_q.int_stat & ~reg_wdata[NUM_EVENTS-1:0];
    r_d.int_stat = r_d.int_stat | events;

    // Read data stands for one cycle only
    live = '0;
    live[E_BIAS_OV] = r_q.ov_fault;
    live[E_FRC_OFF] = r_q.fault;
    live[E_AC_GONE] = ac_ok;
    r_d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_BIAS_CTRL: r_d.rdata = {27'h0, r_q.bias_ctrl};
        ADDR_CMP_CTRL:  r_d.rdata = {24'h0, r_q.cmp_ctrl};
        ADDR_STATUS:    r_d.rdata = {25'h0, r_q.conv_en, r_q.bias_full, r_q.bias_on,
                                     r_q.out_bits, live};
        ADDR_INT_STAT:  r_d.rdata = {29'h0, r_q.int_stat};
        ADDR_INT_MASK:  r_d.rdata = {29'h0, r_q.int_mask};
        default:        r_d.rdata = '0;   // Unmapped reads as zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      r_q           <= '0;
      r_q.bias_ctrl <= BIAS_CTRL_RST;
      r_q.cmp_ctrl  <= CMP_CTRL_RST;
      r_q.out_bits  <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata             = r_q.rdata;
  assign bias_from_system_rail = r_q.bias_sys;
  assign bias_target_low       = ext_sel;
  assign bias_limit_one        = ~ext_sel;
  assign bias_regulator_on     = r_q.bias_on;
  assign bias_full_scale       = r_q.bias_full;
  assign comparator_on         = cmp_act;
  assign comparator_hyst_on    = ~pol_high;
  assign comparator_adc_channel_enable = r_q.cmp_ctrl[C_ADC_EN];
  assign converter_switch_en   = r_q.conv_en;
  assign charge_ok_status_out  = r_q.chg_ok;
  assign irq                   = |(r_q.int_stat & r_q.int_mask);

endmodule

// ---- sim/bias_cmp_ctrl_asserts.sv ----
/*
  Checker bound to the control core's ports.
  Assumes one clock and synchronous reset.
*/
module bias_cmp_ctrl_asserts
  import bias_cmp_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // Register writes
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Pins
  input wire logic        ext_bias_overvoltage,
  input wire logic        comparator_input_pin,
  input wire logic        adapter_present,
  // Outputs watched
  input wire logic        bias_target_low,
  input wire logic        bias_limit_one,
  input wire logic        bias_regulator_on,
  input wire logic        bias_full_scale,
  input wire logic        comparator_on,
  input wire logic        comparator_adc_channel_enable,
  input wire logic        converter_switch_en,
  input wire logic        charge_ok_status_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////
  logic [4:0] bias_q;  // Shadow of bias control
  logic [7:0] cmp_q;   // Shadow of comparator control
  logic [9:0] low_q;   // Cycles of armed low input
  logic       armed;   // Forced-off path in plain setup

  // Sel 0, no latch: timing window known
  assign armed = cmp_q[C_FRC_EN] && !cmp_q[C_IN_SEL] && !cmp_q[C_LATCH_EN]
    && cmp_q[4:3] == 2'b00 && adapter_present && !ext_bias_overvoltage;

  // Shadows follow writes like the core
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      bias_q <= BIAS_CTRL_RST;
      cmp_q  <= CMP_CTRL_RST;
      low_q  <= 10'h000;
    end
    else
    begin
      if (reg_wr && reg_addr == ADDR_BIAS_CTRL)
        bias_q <= reg_wdata[4:0];
      if (reg_wr && reg_addr == ADDR_CMP_CTRL)
        cmp_q <= reg_wdata[7:0];
      // Saturates, so a long fault never wraps
      if (armed && !comparator_input_pin)
        low_q <= low_q + {9'h000, low_q != 10'h3ff};
      else
        low_q <= 10'h000;
    end
  end

  ////////////////////////////////////////
  property p_target; bias_target_low == bias_q[B_EXT_SEL] && bias_limit_one == !bias_target_low;
  endproperty
  a_target: assert property (p_target)
    else $error("bias target wrong");
  property p_ext_ov; ext_bias_overvoltage [*8] |-> !converter_switch_en && !charge_ok_status_out;
  endproperty
  a_ext_ov: assert property (p_ext_ov)
    else $error("ov no stop");
  property p_lp_off;
    (bias_q[B_LP_MODE] && bias_q[4:2] == 3'h0 && !adapter_present) [*8] |-> !bias_regulator_on;
  endproperty
  a_lp_off: assert property (p_lp_off)
    else $error("bias on in low power");
  property p_lp_scaled; (bias_q[B_LP_MODE] && bias_q[4:2] == 3'h1 && !adapter_present) [*8]
    |-> bias_regulator_on && !bias_full_scale; endproperty
  a_lp_scaled: assert property (p_lp_scaled)
    else $error("lp bias unscaled");
  property p_start_full; (bias_q[B_LP_MODE] && bias_q[4:3] != 2'b00) [*4]
    |-> bias_regulator_on && bias_full_scale; endproperty
  a_start_full: assert property (p_start_full)
    else $error("bias reduced");
  property p_perf; (!bias_q[B_LP_MODE]) [*4] |-> bias_regulator_on && bias_full_scale;
  endproperty
  a_perf: assert property (p_perf)
    else $error("perf bias");
  property p_frc_off; low_q >= 10'd50 |-> !converter_switch_en && !charge_ok_status_out;
  endproperty
  a_frc_off: assert property (p_frc_off)
    else $error("no forced off");
  property p_no_early; low_q inside {[10'd1:10'd36]} |-> !$fell(converter_switch_en);
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("early stop");
  property p_adc; comparator_adc_channel_enable == cmp_q[C_ADC_EN]; endproperty
  a_adc: assert property (p_adc)
    else $error("adc enable");
  property p_lp_cmp; (bias_q[B_LP_MODE] && !cmp_q[C_LPCMP_EN] && !adapter_present) [*8]
    |-> !comparator_on; endproperty
  a_lp_cmp: assert property (p_lp_cmp)
    else $error("cmp on unenabled");

  // Main scenarios reached
  c_fall: cover property (converter_switch_en ##1 !converter_switch_en);
  c_scaled: cover property (bias_regulator_on && !bias_full_scale);
  c_ext: cover property (bias_target_low && bias_regulator_on);
endmodule

// ---- sim/host_ec_model.sv ----
/*
  Host model on the core's register port.
  Assumes one-cycle strobes, read data one cycle later.
*/
module host_ec_model
  import bias_cmp_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Register port toward the device
  output      logic [7:0]  reg_addr,
  output      logic [31:0] reg_wdata,
  output      logic        reg_wr,
  output      logic        reg_rd,
  input  wire logic [31:0] reg_rdata
);
  // Idle bus at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Released address and data are inverted so nothing leans on them
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask

  // Read data taken in the one cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata;
  endtask

  // Latch toggle clears a held trigger
  task automatic clear_latch(input logic [31:0] v);
    wr(ADDR_CMP_CTRL, v & ~(32'h1 << C_LATCH_EN));
    wr(ADDR_CMP_CTRL, v);
  endtask
endmodule

// ---- sim/bias_ldo_and_comparator_ctrl_bench.sv ----
/*
  Self-checking bench for the control core.
  Assumes the host model owns the register port.
*/
module bias_ldo_and_comparator_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bias_cmp_pkg::*;

  ////////////////////////////////////////
  logic        sys_clk, srst, reg_wr, reg_rd;      // Clock, reset, strobes
  logic [7:0]  reg_addr;                           // Register address
  logic [31:0] reg_wdata, reg_rdata, d;            // Bus data, read value
  logic        in6, sys6, in_gt, ov, cmp_pin, ac;  // Analog levels
  logic        src_sys, tgt_low, lim1, b_on, b_full, c_on, hyst, adc, conv, cok, irq;
  int          error_cnt, tests_run, n, g;         // Counters
  int          bias_m, cmp_m;                      // Model of control registers
  int          deg_n [4] = '{DEG0_CYC, DEG1_CYC, DEG2_CYC, DEG3_CYC};
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'hfc};

  bias_cmp_ctrl dut (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_rail_above_6v(in6), .system_rail_above_6v(sys6),
    .input_rail_above_system(in_gt), .ext_bias_overvoltage(ov),
    .comparator_input_pin(cmp_pin), .adapter_present(ac),
    .bias_from_system_rail(src_sys), .bias_target_low(tgt_low), .bias_limit_one(lim1),
    .bias_regulator_on(b_on), .bias_full_scale(b_full), .comparator_on(c_on),
    .comparator_hyst_on(hyst), .comparator_adc_channel_enable(adc),
    .converter_switch_en(conv), .charge_ok_status_out(cok), .irq(irq));
  host_ec_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Settle past the edge
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Host write, model kept in step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.wr(a, v);
    if (a == ADDR_BIAS_CTRL)
      bias_m = v & 32'h1f;
    if (a == ADDR_CMP_CTRL)
      cmp_m = v & 32'hff;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host.rd(a, d);
    chk("reg_read", exp, d);
  endtask

  // Pin step, cycles until converter follows
  task automatic measure(input logic lvl);
    @(posedge sys_clk) cmp_pin <= lvl;
    n = 0;
    while (conv !== lvl && n < 900)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    {in6, sys6, in_gt, ov, ac} = 5'h00;
    cmp_pin   = 1'b1;
    srst      = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    bias_m    = BIAS_CTRL_RST;
    cmp_m     = CMP_CTRL_RST;
    void'($urandom(36166));
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values, unmapped places read zero
    foreach (ra[k])
      rd_chk(ra[k], ra[k] == 8'h00 ? bias_m : ra[k] == 8'h04 ? cmp_m : 0);
    chk("bias_on", 0, b_on);
    chk("target", 0, tgt_low);
    chk("limit1", 1, lim1);
    chk("cmp_on", 0, c_on);
    $display("reset test done");
    // Every rail combination
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk) {in6, sys6, in_gt} <= i[2:0];
      tick(8);
      chk("bias_src", (i[2] & i[1]) ? i[0] : (!i[2] & !i[1]) ? !i[0] : i[1], src_sys);
    end
    $display("source test done");
    // Bias modes on battery alone
    wr(ADDR_BIAS_CTRL, 32'h06);
    tick(8);
    chk("lp_bias", 2, {b_on, b_full});
    wr(ADDR_BIAS_CTRL, 32'h0e);
    tick(8);
    chk("otg_full", 3, {b_on, b_full});
    wr(ADDR_BIAS_CTRL, 32'h12);
    tick(8);
    chk("vap_full", 3, {b_on, b_full});
    wr(ADDR_BIAS_CTRL, 32'h01);
    tick(8);
    chk("perf_full", 3, {b_on, b_full});
    chk("ext_target", 2, {tgt_low, lim1});
    rd_chk(ADDR_BIAS_CTRL, bias_m);
    $display("bias test done");
    // Bias overvoltage, sticky event, mask
    @(posedge sys_clk) ac <= 1'b1;
    tick(8);
    chk("conv_on", 1, conv);
    wr(ADDR_INT_MASK, 32'h1);
    @(posedge sys_clk) ov <= 1'b1;
    tick(8);
    chk("ov_stop", 0, {conv, cok});
    rd_chk(ADDR_STATUS, 32'h3d);
    chk("irq_set", 1, irq);
    @(posedge sys_clk) ov <= 1'b0;
    wr(ADDR_INT_MASK, 32'h0);
    tick(8);
    chk("irq_mask", 0, irq);
    rd_chk(ADDR_INT_STAT, 32'h1);
    wr(ADDR_INT_STAT, 32'h1);
    rd_chk(ADDR_INT_STAT, 32'h0);
    $display("overvoltage test done");
    // Each deglitch code: glitch, fall, rise
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_CMP_CTRL, 32'h20 | (s << 3));
      @(posedge sys_clk) cmp_pin <= 1'b0;
      tick(deg_n[s] / 2);
      @(posedge sys_clk) cmp_pin <= 1'b1;
      g = 0;
      repeat (deg_n[s] + 8)
      begin
        tick(1);
        g += (conv !== 1'b1);
      end
      chk("glitch", 0, g);
      measure(1'b0);
      chk("fall", 1, n >= deg_n[s] && n <= deg_n[s] + 8);
      chk("cok_low", 0, cok);
      host.rd(ADDR_STATUS, d);
      chk("frc_fault", 1, d[E_FRC_OFF]);
      measure(1'b1);
      chk("rise", 1, n >= deg_n[s] && n <= deg_n[s] + 8);
    end
    $display("deglitch test done");
    // Latched trigger held until enable toggles
    wr(ADDR_CMP_CTRL, 32'h22);
    measure(1'b0);
    @(posedge sys_clk) cmp_pin <= 1'b1;
    tick(60);
    chk("latched", 0, conv);
    host.clear_latch(32'h22);
    tick(8);
    chk("unlatched", 1, conv);
    $display("latch test done");
    // Removal with input low re-raises fault
    wr(ADDR_CMP_CTRL, 32'h20);
    wr(ADDR_INT_STAT, 32'h7);
    measure(1'b0);
    wr(ADDR_INT_STAT, 32'h2);
    @(posedge sys_clk) ac <= 1'b0;
    tick(10);
    rd_chk(ADDR_INT_STAT, 32'h6);
    host.rd(ADDR_STATUS, d);
    chk("frc_kept", 1, d[E_FRC_OFF]);
    @(posedge sys_clk) cmp_pin <= 1'b1;
    $display("removal test done");
    // Random comparator setups, battery only
    wr(ADDR_BIAS_CTRL, 32'h02);
    tick(10);
    chk("lp_off", 0, b_on);
    repeat (8)
    begin
      wr(ADDR_CMP_CTRL, $urandom & 32'hc5);
      tick(8);
      chk("adc_en", cmp_m[6], adc);
      chk("cmp_on", cmp_m[7] & !cmp_m[0], c_on);
      if (c_on === 1'b1)
        chk("hyst", !cmp_m[2], hyst);
      rd_chk(ADDR_CMP_CTRL, cmp_m);
    end
    $display("random test done");
    conclude();
  end
endmodule

bind bias_cmp_ctrl bias_cmp_ctrl_asserts u_chk (
  .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .ext_bias_overvoltage(ext_bias_overvoltage),
  .comparator_input_pin(comparator_input_pin), .adapter_present(adapter_present),
  .bias_target_low(bias_target_low), .bias_limit_one(bias_limit_one),
  .bias_regulator_on(bias_regulator_on), .bias_full_scale(bias_full_scale),
  .comparator_on(comparator_on),
  .comparator_adc_channel_enable(comparator_adc_channel_enable),
  .converter_switch_en(converter_switch_en), .charge_ok_status_out(charge_ok_status_out));
